// [pkg/sdram_bank_pkg.sv]
// package: command codes, bank states, timing counts and carriers for the
// two-bank synchronous dram command-response block.
// assumes a 250 MHz clock (4 ns period).
`default_nettype none
package sdram_bank_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  // timing figures in ps; plain defaults, not taken from any part
  localparam int ROW_PRECHARGE_TIME_PS = 20000;
  localparam int ACTIVATE_TO_COLUMN_DELAY_PS = 20000;
  localparam int DATA_IN_TO_PRECHARGE_TIME_PS = 8000;
  // least times round up
  localparam int ROW_PRECHARGE_CYC =
    (ROW_PRECHARGE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACTIVATE_TO_COLUMN_CYC =
    (ACTIVATE_TO_COLUMN_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DATA_IN_TO_PRECHARGE_CYC =
    (DATA_IN_TO_PRECHARGE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;
  localparam int COL_W = 8;
  localparam int ROW_W = 11;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int BANK_SEL_BIT = 11;
  localparam int AUTO_PRE_BIT = 10;
  localparam logic [3:0] BURST_LEN_DEFAULT = 4'h4;

  // {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    nop_cmd = 4'h7,
    burst_terminate_cmd = 4'h6,
    read_cmd = 4'h5,
    write_cmd = 4'h4,
    activate_cmd = 4'h3,
    precharge_cmd = 4'h2,
    refresh_cmd = 4'h1,
    mode_register_set_cmd = 4'h0
  } cmd_e;

  typedef enum logic [8:0] {
    st_idle = 9'h001,
    st_activating = 9'h002,
    st_row_active = 9'h004,
    st_read = 9'h008,
    st_write = 9'h010,
    st_read_ap = 9'h020,
    st_write_ap = 9'h040,
    st_write_recovery = 9'h080,
    st_precharging = 9'h100
  } bank_state_e;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [11:0] addr;
  } cmd_pins_s;

  typedef struct packed {
    logic is_write;
    logic bank;
    logic [COL_W-1:0] col;
    logic [DATA_W-1:0] data;
  } beat_s;
endpackage : sdram_bank_pkg
`default_nettype wire

// [rtl/beat_fifo.sv]
// small synchronous fifo for burst beats.
// assumes one clock, synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module beat_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [WIDTH-1:0] out_data_reg;
  logic out_valid_reg, out_valid_next;
  logic push, pop, empty;

  assign empty = (wr_reg == rd_reg);
  assign in_ready = !((wr_reg[AW] != rd_reg[AW]) &&
                       (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
  assign push = in_valid && in_ready;
  // output register refills when drained or empty
  assign pop = !empty && (!out_valid_reg || out_ready);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  always_comb
  begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    out_valid_next = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid_reg);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      out_valid_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      out_valid_reg <= out_valid_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_reg[AW-1:0]] <= in_data;
    if (pop)
      out_data_reg <= mem[rd_reg[AW-1:0]];
  end
endmodule : beat_fifo
`default_nettype wire

// [rtl/sdram_bank_cmd.sv]
// per-bank command response of a two-bank synchronous dram.
// assumes pins already in the clk domain; sampled on rising edge.
// limitation: only one beat per cycle reaches the fifo across banks.
`timescale 1ns/10ps
`default_nettype none
// Operation
// [RQ1] read burst with nop/deselect completes, then row active
// [RQ2] burst terminate during read ends burst, row active
// [RQ3] new read during read restarts burst at new column
// [RQ4] write during read interrupts read, starts write burst
// [RQ5] precharge during read interrupts and precharges the row
// [RQ6] write burst with nop completes, then write recovery
// [RQ7] burst terminate during write ends write, row active
// [RQ8] read during write ends write, starts read at new column
// [RQ9] new write during write restarts at new column
// [RQ10] precharge during write interrupts and precharges the row
// [RQ11] read with auto-precharge completes then precharges itself
// [RQ12] write with auto-precharge completes, recovers, then precharges
// [RQ13] precharging ignores nop/terminate; idle after row precharge time
// [RQ14] after activate, row active only after activate-to-column delay
// [RQ15] all command and address pins sampled on rising clock edge
// [RQ16] controller uses burst terminate only with full-page bursts
// [RQ17] write recovery returns to row active after data-in time
// [RQ18] controller avoids illegal commands to busy banks; t_refuse sends an activate to bank 0 while it reads
// [RQ19] controller sends only nop to auto-precharge bursting bank
module sdram_bank_cmd (
  input wire logic clk,
  input wire logic sys_rst,
  input wire sdram_bank_pkg::cmd_pins_s cmd_pins,
  input wire logic [sdram_bank_pkg::DATA_W-1:0] write_data,
  input wire logic [3:0] burst_len,
  input wire logic full_page,
  output sdram_bank_pkg::bank_state_e bank0_state,
  output sdram_bank_pkg::bank_state_e bank1_state,
  output logic illegal_cmd,
  output logic beat_valid,
  input wire logic beat_ready,
  output sdram_bank_pkg::beat_s beat_out,
  output logic cmd_ready
);
  import sdram_bank_pkg::*;

  cmd_pins_s pins_reg;
  cmd_e cmd;
  logic sel_bank;
  logic all_banks;
  logic illegal_reg, illegal_next;
  logic [1:0] bank_illegal;
  logic [1:0] beat_push;
  logic fifo_in_ready;
  beat_s beat_in;
  bank_state_e st_reg [2];
  bank_state_e st_next [2];
  logic [CNT_W-1:0] cnt_reg [2];
  logic [CNT_W-1:0] cnt_next [2];
  logic [COL_W-1:0] col_reg [2];
  logic [COL_W-1:0] col_next [2];
  logic [ROW_W-1:0] row_reg [2];
  logic [ROW_W-1:0] row_next [2];
  logic [1:0] ap_recov_reg;
  logic [1:0] ap_recov_next;

  // command pins registered once: every decision uses the edge sample
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pins_reg <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                    addr: 12'h000};
    else
      pins_reg <= cmd_pins; // RQ15
  end

  // deselect folds into nop: both just let the bank carry on
  assign cmd = pins_reg.cs_n ? nop_cmd :
               cmd_e'({1'b0, pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n});
  assign sel_bank = pins_reg.addr[BANK_SEL_BIT];
  assign all_banks = pins_reg.addr[AUTO_PRE_BIT];
  // fifo full asks the controller to hold off; a burst already running
  // keeps stepping and its beats are lost while the fifo stays full
  assign cmd_ready = fifo_in_ready;

  // one state machine per bank; both share the sampled command
  genvar b;
  generate
    for (b = 0; b < 2; b++)
    begin : g_bank
      logic hit;
      logic pre_hit;
      logic burst_done;
      assign hit = (sel_bank == 1'(b));
      assign pre_hit = hit || all_banks;
      // full page wraps until terminated or interrupted
      // count holds beats already sent, so done marks the last one
      assign burst_done = !full_page &&
                          (cnt_reg[b] == CNT_W'(burst_len) - 1'b1);

      always_comb
      begin
        st_next[b] = st_reg[b];
        cnt_next[b] = cnt_reg[b];
        col_next[b] = col_reg[b];
        row_next[b] = row_reg[b];
        bank_illegal[b] = 1'b0;
        beat_push[b] = 1'b0;
        unique case (st_reg[b])
          st_idle:
          begin
            if (cmd == activate_cmd && hit)
            begin
              st_next[b] = st_activating;
              row_next[b] = pins_reg.addr[ROW_W-1:0];
              cnt_next[b] = '0;
            end
            else if ((cmd == read_cmd || cmd == write_cmd) && hit)
              bank_illegal[b] = 1'b1;
          end
          st_activating:
          begin
            // early column commands are refused, never queued
            cnt_next[b] = cnt_reg[b] + 1'b1;
            if (cnt_reg[b] == CNT_W'(ACTIVATE_TO_COLUMN_CYC - 1))
              st_next[b] = st_row_active; // RQ14
            if (hit && cmd != nop_cmd && cmd != burst_terminate_cmd)
              bank_illegal[b] = 1'b1; // RQ18
          end
          st_row_active, st_read, st_write, st_write_recovery:
          begin
            // row open: idle in the row, bursting or recovering
            if (st_reg[b] == st_read || st_reg[b] == st_write)
            begin
              beat_push[b] = 1'b1;
              col_next[b] = col_reg[b] + 1'b1;
              cnt_next[b] = cnt_reg[b] + 1'b1;
              if (burst_done && st_reg[b] == st_read)
                st_next[b] = st_row_active; // RQ1
              else if (burst_done)
              begin
                st_next[b] = st_write_recovery; // RQ6
                cnt_next[b] = '0;
              end
            end
            if (st_reg[b] == st_write_recovery)
            begin
              cnt_next[b] = cnt_reg[b] + 1'b1;
              if (cnt_reg[b] == CNT_W'(DATA_IN_TO_PRECHARGE_CYC - 1))
              begin
                cnt_next[b] = '0;
                if (ap_recov_reg[b])
                  st_next[b] = st_precharging; // RQ12
                else
                  st_next[b] = st_row_active; // RQ17
              end
            end
            if (st_reg[b] == st_write_recovery && ap_recov_reg[b])
            begin
              if (hit && cmd != nop_cmd && cmd != burst_terminate_cmd)
                bank_illegal[b] = 1'b1; // RQ19
            end
            else if (cmd == burst_terminate_cmd &&
                (st_reg[b] == st_read || st_reg[b] == st_write))
              st_next[b] = st_row_active; // RQ2 RQ7
            else if ((cmd == read_cmd || cmd == write_cmd) && hit)
            begin
              // restart at the new column
              col_next[b] = pins_reg.addr[COL_W-1:0]; // RQ3 RQ4 RQ8 RQ9
              cnt_next[b] = '0;
              if (cmd == read_cmd)
                st_next[b] = all_banks ? st_read_ap : st_read;
              else
                st_next[b] = all_banks ? st_write_ap : st_write;
            end
            else if (cmd == precharge_cmd && pre_hit)
            begin
              if (st_reg[b] == st_write_recovery)
                bank_illegal[b] = 1'b1;
              else
              begin
                st_next[b] = st_precharging; // RQ5 RQ10
                cnt_next[b] = '0;
              end
            end
            else if (hit && (cmd == activate_cmd || cmd == refresh_cmd ||
                             cmd == mode_register_set_cmd))
              bank_illegal[b] = 1'b1; // RQ18
          end
          st_read_ap, st_write_ap:
          begin
            // write recovery precedes the automatic precharge
            beat_push[b] = 1'b1;
            col_next[b] = col_reg[b] + 1'b1;
            cnt_next[b] = cnt_reg[b] + 1'b1;
            if (burst_done)
            begin
              cnt_next[b] = '0;
              if (st_reg[b] == st_read_ap)
                st_next[b] = st_precharging; // RQ11
              else
                st_next[b] = st_write_recovery; // RQ12
            end
            if (hit && cmd != nop_cmd)
              bank_illegal[b] = 1'b1; // RQ19
          end
          st_precharging:
          begin
            cnt_next[b] = cnt_reg[b] + 1'b1;
            if (cnt_reg[b] == CNT_W'(ROW_PRECHARGE_CYC - 1))
              st_next[b] = st_idle; // RQ13
            if (hit && (cmd == read_cmd || cmd == write_cmd ||
                        cmd == activate_cmd || cmd == refresh_cmd ||
                        cmd == mode_register_set_cmd))
              bank_illegal[b] = 1'b1; // RQ18
          end
          default:
            st_next[b] = st_idle;
        endcase
      end

      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          st_reg[b] <= st_idle;
          cnt_reg[b] <= '0;
          col_reg[b] <= '0;
          row_reg[b] <= '0;
        end
        else
        begin
          st_reg[b] <= st_next[b];
          cnt_reg[b] <= cnt_next[b];
          col_reg[b] <= col_next[b];
          row_reg[b] <= row_next[b];
        end
      end
    end
  endgenerate

  // write recovery entered from an auto-precharge write must end in a
  // precharge; a flag per bank keeps plain recovery returning to active
  // and refuses commands while the row closes itself
  always_comb
  begin
    ap_recov_next = ap_recov_reg;
    for (int i = 0; i < 2; i++)
    begin
      if (st_reg[i] == st_write_ap && st_next[i] == st_write_recovery)
        ap_recov_next[i] = 1'b1;
      else if (st_reg[i] != st_write_recovery)
        ap_recov_next[i] = 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ap_recov_reg <= 2'h0;
    else
      ap_recov_reg <= ap_recov_next;
  end

  // one beat per cycle: bank 0 wins when both burst, which a single data
  // bus never legally asks for
  always_comb
  begin
    beat_in.is_write = (st_reg[0] == st_write || st_reg[0] == st_write_ap);
    beat_in.bank = 1'b0;
    beat_in.col = col_reg[0];
    beat_in.data = write_data;
    if (!beat_push[0])
    begin
      beat_in.is_write = (st_reg[1] == st_write || st_reg[1] == st_write_ap);
      beat_in.bank = 1'b1;
      beat_in.col = col_reg[1];
    end
    illegal_next = |bank_illegal;
  end

  // one-cycle pulse per refused command; nothing to clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      illegal_reg <= 1'b0;
    else
      illegal_reg <= illegal_next;
  end

  // depth rides out a short stall of the beat consumer
  beat_fifo #(
    .WIDTH($bits(beat_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(|beat_push),
    .in_ready(fifo_in_ready),
    .in_data(beat_in),
    .out_valid(beat_valid),
    .out_ready(beat_ready),
    .out_data(beat_out)
  );

  // state outputs come straight from the bank registers
  assign bank0_state = st_reg[0];
  assign bank1_state = st_reg[1];
  assign illegal_cmd = illegal_reg;
endmodule : sdram_bank_cmd
`default_nettype wire

// [bench/sdram_ctrl_model.sv]
// controller model: issues commands, feeds write data, takes beats.
// assumes cmd_ready from the block; commands change after rising edges.
`timescale 1ns/10ps
`default_nettype none
module sdram_ctrl_model
  import sdram_bank_pkg::*;
(
  input wire logic clk,
  input wire logic cmd_ready,
  output sdram_bank_pkg::cmd_pins_s cmd_pins,
  output logic [15:0] write_data,
  output logic beat_ready
);
  logic stall = 1'b0;
  initial
  begin
    cmd_pins = 16'hF000;
    write_data = 16'h0000;
    beat_ready = 1'b1;
  end
  // data changes every cycle so a stale beat cannot pass for a fresh one
  always @(posedge clk)
  begin
    write_data <= write_data + 16'h0001;
    beat_ready <= !stall;
  end
  // the block takes the pins at every edge: wait for room first, then
  // let the command stand for exactly one cycle
  task issue(cmd_e c, logic bk, logic a10, logic [7:0] col);
    @(posedge clk);
    while (cmd_ready !== 1'b1)
      @(posedge clk);
    cmd_pins <= {c, bk, a10, 2'b00, col};
    @(posedge clk);
    // deselect between commands; address shows its inverse
    cmd_pins <= {4'hF, ~cmd_pins.addr};
  endtask : issue
endmodule : sdram_ctrl_model
`default_nettype wire

// [bench/sdram_bank_cmd_assertions.sv]
// checker: bank0 command response timing and beat hold.
// assumes it is bound into sdram_bank_cmd.
`timescale 1ns/10ps
`default_nettype none
module sdram_bank_cmd_assertions
  import sdram_bank_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire sdram_bank_pkg::cmd_pins_s cmd_pins,
  input wire sdram_bank_pkg::bank_state_e bank0_state,
  input wire logic illegal_cmd,
  input wire logic beat_valid,
  input wire logic beat_ready,
  input wire sdram_bank_pkg::beat_s beat_out
);
  logic [3:0] c;
  logic nb;
  logic pb;
  bank_state_e s;
  assign c = cmd_pins[15:12];
  assign nb = !cmd_pins.addr[11];
  assign pb = nb || cmd_pins.addr[10];
  assign s = bank0_state;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_act0;
    c == activate_cmd && nb && s == st_idle;
  endsequence
  sequence s_row_wait;
    (s == st_activating)[*5] ##1 s == st_row_active;
  endsequence
  sequence s_pre_wait;
    (s == st_precharging)[*5] ##1 s == st_idle;
  endsequence
  a_act_delay:
    assert property (s_act0 |-> ##2 s_row_wait)
    else $error("activate delay wrong");
  a_pre_time:
    assert property ($rose(s == st_precharging) |-> s_pre_wait)
    else $error("precharge time wrong");
  a_bst_read:
    assert property (c == burst_terminate_cmd && s == st_read
      |-> ##2 s == st_row_active) else $error("terminate missed");
  a_read_read:
    assert property (c == read_cmd && nb && s == st_read
      |-> ##2 s inside {st_read, st_read_ap}) else $error("no restart");
  a_read_write:
    assert property (c == write_cmd && nb && s == st_read
      |-> ##2 s inside {st_write, st_write_ap}) else $error("no write");
  a_read_pre:
    assert property (c == precharge_cmd && pb && s == st_read
      |-> ##2 s == st_precharging) else $error("no precharge");
  a_act_refused:
    assert property (c == activate_cmd && nb && s == st_read
      |-> ##2 (illegal_cmd && s == st_read)) else $error("not refused");
  a_beat_hold:
    assert property (beat_valid && !beat_ready
      |=> beat_valid && $stable(beat_out)) else $error("beat moved");
endmodule : sdram_bank_cmd_assertions
bind sdram_bank_cmd sdram_bank_cmd_assertions i_sdram_bank_cmd_assertions (
  .clk(clk), .sys_rst(sys_rst), .cmd_pins(cmd_pins),
  .bank0_state(bank0_state), .illegal_cmd(illegal_cmd),
  .beat_valid(beat_valid), .beat_ready(beat_ready), .beat_out(beat_out)
);
`default_nettype wire

// [bench/sdram_bank_cmd_tb.sv]
// testbench: bank0 burst and state command responses, beat fifo.
// assumes the controller model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module sdram_bank_cmd_tb;
  import sdram_bank_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  cmd_pins_s cmd_pins;
  logic [15:0] write_data;
  logic full_page = 1'b0;
  logic [3:0] burst_len = 4'h4;
  bank_state_e s0;
  bank_state_e s1;
  logic illegal_cmd;
  logic beat_valid;
  logic beat_ready;
  logic cmd_ready;
  beat_s beat_out;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  sdram_ctrl_model i_sdram_ctrl_model (.clk(clk), .cmd_ready(cmd_ready),
    .cmd_pins(cmd_pins), .write_data(write_data), .beat_ready(beat_ready));
  sdram_bank_cmd i_sdram_bank_cmd (.clk(clk), .sys_rst(sys_rst),
    .cmd_pins(cmd_pins), .write_data(write_data), .burst_len(burst_len),
    .full_page(full_page), .bank0_state(s0), .bank1_state(s1),
    .illegal_cmd(illegal_cmd), .beat_valid(beat_valid),
    .beat_ready(beat_ready), .beat_out(beat_out), .cmd_ready(cmd_ready));
  task test_done;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // whole run needs a few hundred cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      test_done();
    end
  end
  task chk_st(bank_state_e g, bank_state_e e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask : chk_st
  task chk_val(logic [15:0] g, logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask : chk_val
  task wait_st(bank_state_e e, int n);
    for (int i = 0; i < n && s0 !== e; i++)
      @(negedge clk);
    chk_st(s0, e);
  endtask : wait_st
  // counts the cycles bank 0 spends in one state
  task burst_chk(bank_state_e e, logic [3:0] len);
    int n;
    n = 0;
    wait_st(e, 3);
    while (s0 === e && n < 20)
    begin
      n++;
      @(negedge clk);
    end
    chk_val(16'(n), 16'(len));
  endtask : burst_chk
  // a restarted burst shows its first beat at the new column
  task chk_restart(logic wr);
    for (int i = 0; i < 20 && !(beat_valid === 1'b1 &&
         beat_out.col === 8'h30); i++)
      @(negedge clk);
    chk_val(16'({beat_valid, beat_out.is_write, beat_out.col}),
            16'({1'b1, wr, 8'h30}));
  endtask : chk_restart
  task cmd(cmd_e c, logic a10, logic [7:0] col);
    i_sdram_ctrl_model.issue(c, 1'b0, a10, col);
  endtask : cmd
  task open_row(logic fp);
    @(posedge clk) full_page <= fp;
    cmd(activate_cmd, 1'b0, 8'h00);
    wait_st(st_activating, 3);
    wait_st(st_row_active, 8);
  endtask : open_row
  task close_all;
    cmd(precharge_cmd, 1'b1, 8'h00);
    wait_st(st_idle, 14);
    chk_st(s1, st_idle);
  endtask : close_all
  task t_done;
    open_row(1'b0);
    cmd(read_cmd, 1'b0, 8'h10);
    burst_chk(st_read, 4'h4);
    wait_st(st_row_active, 2);
    @(posedge clk) burst_len <= 4'h8;
    cmd(write_cmd, 1'b0, 8'h20);
    burst_chk(st_write, 4'h8);
    burst_chk(st_write_recovery, 4'(DATA_IN_TO_PRECHARGE_CYC));
    chk_st(s0, st_row_active);
    @(posedge clk) burst_len <= 4'h4;
    close_all();
  endtask : t_done
  // full page keeps the first burst running until the interrupt
  task t_intr(cmd_e first, cmd_e second, bank_state_e e);
    open_row(1'b1);
    cmd(first, 1'b0, 8'h20);
    wait_st(first == read_cmd ? st_read : st_write, 3);
    cmd(second, 1'b0, 8'h30);
    wait_st(e, 3);
    if (second == read_cmd || second == write_cmd)
      chk_restart(second == write_cmd);
    if (e != st_precharging)
      cmd(precharge_cmd, 1'b1, 8'h00);
    wait_st(st_idle, 14);
  endtask : t_intr
  task t_auto;
    open_row(1'b0);
    cmd(read_cmd, 1'b1, 8'h00);
    wait_st(st_read_ap, 3);
    wait_st(st_precharging, 10);
    wait_st(st_idle, 8);
    open_row(1'b0);
    cmd(write_cmd, 1'b1, 8'h00);
    wait_st(st_write_ap, 3);
    wait_st(st_precharging, 14);
    wait_st(st_idle, 8);
  endtask : t_auto
  task t_refuse;
    open_row(1'b1);
    cmd(read_cmd, 1'b0, 8'h00);
    wait_st(st_read, 3);
    cmd(activate_cmd, 1'b0, 8'h00);
    repeat (2) @(negedge clk);
    chk_val(16'(illegal_cmd), 16'h0001);
    @(negedge clk);
    chk_val(16'(illegal_cmd), 16'h0000);
    chk_st(s0, st_read);
    close_all();
  endtask : t_refuse
  task t_fifo;
    int i;
    open_row(1'b1);
    i_sdram_ctrl_model.stall = 1'b1;
    cmd(write_cmd, 1'b0, 8'h40);
    for (i = 0; i < 40 && cmd_ready !== 1'b0; i++)
      @(negedge clk);
    chk_val(16'(cmd_ready), 16'h0000);
    chk_val({beat_out.is_write, beat_out.col}, 16'h0140);
    i_sdram_ctrl_model.stall = 1'b0;
    cmd(burst_terminate_cmd, 1'b0, 8'h00);
    wait_st(st_row_active, 12);
    for (i = 0; i < 40 && beat_valid !== 1'b0; i++)
      @(negedge clk);
    chk_val(16'(beat_valid), 16'h0000);
    close_all();
  endtask : t_fifo
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk_st(s0, st_idle);
    chk_st(s1, st_idle);
    t_done();
    t_intr(read_cmd, burst_terminate_cmd, st_row_active);
    t_intr(read_cmd, read_cmd, st_read);
    t_intr(read_cmd, write_cmd, st_write);
    t_intr(read_cmd, precharge_cmd, st_precharging);
    t_intr(write_cmd, burst_terminate_cmd, st_row_active);
    t_intr(write_cmd, read_cmd, st_read);
    t_intr(write_cmd, write_cmd, st_write);
    t_intr(write_cmd, precharge_cmd, st_precharging);
    t_auto();
    t_refuse();
    t_fifo();
    test_done();
  end
endmodule : sdram_bank_cmd_tb
`default_nettype wire
